/* design/asc_pkg.sv */
// Constants for the audio serial control register block
package asc_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFF_TXWIN   = 8'h00;
	localparam logic [7:0]  OFF_RXWIN   = 8'h04;
	localparam logic [7:0]  OFF_CONF    = 8'h08;
	localparam logic [7:0]  OFF_RAW     = 8'h0C;
	localparam logic [7:0]  OFF_MASKED  = 8'h10;
	localparam logic [7:0]  OFF_ENA     = 8'h14;
	localparam logic [7:0]  OFF_CLR     = 8'h18;
	localparam logic [7:0]  OFF_TIMEOUT = 8'h1C;

	// ----------------------------------------------------------------
	// Configuration field positions
	// ----------------------------------------------------------------
	localparam int CF_TX_RESET       = 0;
	localparam int CF_RX_RESET       = 1;
	localparam int CF_TX_FIFO_RESET  = 2;
	localparam int CF_RX_FIFO_RESET  = 3;
	localparam int CF_TX_START       = 4;
	localparam int CF_RX_START       = 5;
	localparam int CF_TX_EXT_CLK     = 6;
	localparam int CF_RX_EXT_CLK     = 7;
	localparam int CF_TX_RIGHT_FIRST = 8;
	localparam int CF_RX_RIGHT_FIRST = 9;
	localparam int CF_TX_ONE_DELAY   = 10;
	localparam int CF_RX_ONE_DELAY   = 11;
	localparam int CF_TX_SHORT_SYNC  = 12;
	localparam int CF_RX_SHORT_SYNC  = 13;
	localparam int CF_TX_MONO        = 14;
	localparam int CF_RX_MONO        = 15;
	localparam int CF_TX_RIGHT_TOP   = 16;
	localparam int CF_RX_RIGHT_TOP   = 17;
	localparam int CF_LOOPBACK       = 18;
	localparam int CONF_W            = 19;

	// ----------------------------------------------------------------
	// Event bit positions
	// ----------------------------------------------------------------
	localparam int EV_RX_HIGH_LEVEL  = 0;
	localparam int EV_TX_LOW_LEVEL   = 1;
	localparam int EV_RX_QUEUE_FULL  = 2;
	localparam int EV_RX_QUEUE_EMPTY = 3;
	localparam int EV_TX_QUEUE_FULL  = 4;
	localparam int EV_TX_QUEUE_EMPTY = 5;
	localparam int EV_RX_TIMEOUT     = 6;
	localparam int EV_TX_TIMEOUT     = 7;
	localparam int EV_W              = 16;

	// ----------------------------------------------------------------
	// Reset values, FIFO shape, timing
	// ----------------------------------------------------------------
	localparam logic [CONF_W-1:0] CONF_RST    = 19'h00000;
	localparam logic [15:0]       ENA_RST     = 16'h0000;
	localparam logic [15:0]       RAW_RST     = 16'h0000;
	localparam logic [15:0]       TIMEOUT_RST = 16'h0FFF;
	localparam int                FIFO_AW     = 3;
	localparam logic [3:0]        AEMPTY_LVL  = 4'h2;
	localparam logic [3:0]        AFULL_LVL   = 4'h6;
	localparam int                CLK_PERIOD_NS = 10;
	localparam int                BCK_PERIOD_NS = 80;
	localparam int                BCK_HALF    = BCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [1:0]        RESP_OKAY   = 2'h0;
	localparam logic [1:0]        RESP_SLVERR = 2'h2;

endpackage

/* design/asc_fifo.sv */
// Sample FIFO held in flip-flops
`timescale 1ns/10ps
`default_nettype none
module asc_fifo (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clr,
	input  wire logic        push,
	input  wire logic [31:0] wdata,
	input  wire logic        pop,
	output logic      [31:0] rdata,
	output logic             full,
	output logic             empty,
	output logic      [3:0]  level
);
	localparam int AW = asc_pkg::FIFO_AW;

	logic [31:0]   mem_q [2**AW];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          do_push;
	logic          do_pop;

	assign full    = cnt_q[AW];
	assign empty   = (cnt_q == '0);
	assign level   = 4'(cnt_q);
	assign rdata   = mem_q[rd_q];
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[wr_q] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clr) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_q + AW'(do_push);
			rd_q  <= rd_q + AW'(do_pop);
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule // asc_fifo
`default_nettype wire

/* design/asc_regs.sv */
// Register front end and serial engines of the audio serial port
`timescale 1ns/10ps
`default_nettype none
module asc_regs (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        bck_in,
	input  wire logic        ws_in,
	input  wire logic        sd_in,
	output logic             bck_out,
	output logic             ws_out,
	output logic             sd_out,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_q;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Registers and bus slave
	// ----------------------------------------------------------------
	logic [asc_pkg::CONF_W-1:0] conf_q;
	logic [15:0] ena_q;
	logic [15:0] raw_q;
	logic [15:0] tmo_q;
	logic [15:0] ev_set;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_wr;
	logic [31:0] wmask;
	logic [31:0] rd_mux;
	logic        rd_hit;
	logic        wr_hit;
	logic        ar_take;
	logic [31:0] rx_rdata;
	logic        rx_empty;
	logic        tx_push;
	logic        rx_pop;
	logic [15:0] clr_bits;

	assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_wr   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign tx_push = do_wr && awaddr_q == asc_pkg::OFF_TXWIN && wstrb_q != 4'h0;
	assign rx_pop  = ar_take && s_axi_araddr == asc_pkg::OFF_RXWIN;
	assign clr_bits = (do_wr && awaddr_q == asc_pkg::OFF_CLR) ? wdata_q[15:0] & wmask[15:0]
	                                                          : 16'h0000;

	always_comb begin
		wr_hit = 1'b1;
		case (awaddr_q)
			asc_pkg::OFF_TXWIN, asc_pkg::OFF_RXWIN, asc_pkg::OFF_CONF, asc_pkg::OFF_RAW,
			asc_pkg::OFF_MASKED, asc_pkg::OFF_ENA, asc_pkg::OFF_CLR,
			asc_pkg::OFF_TIMEOUT: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			asc_pkg::OFF_RXWIN:   rd_mux = rx_empty ? 32'h0000_0000 : rx_rdata;
			asc_pkg::OFF_CONF:    rd_mux = 32'(conf_q);
			asc_pkg::OFF_RAW:     rd_mux = {16'h0000, raw_q};
			asc_pkg::OFF_MASKED:  rd_mux = {16'h0000, raw_q & ena_q};
			asc_pkg::OFF_ENA:     rd_mux = {16'h0000, ena_q};
			asc_pkg::OFF_TIMEOUT: rd_mux = {16'h0000, tmo_q};
			asc_pkg::OFF_TXWIN, asc_pkg::OFF_CLR: rd_mux = 32'h0000_0000;
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_q    <= 1'b0;
			w_hold_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= asc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= asc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			conf_q <= asc_pkg::CONF_RST;
			ena_q  <= asc_pkg::ENA_RST;
			tmo_q  <= asc_pkg::TIMEOUT_RST;
		end else if (do_wr) begin
			case (awaddr_q)
				asc_pkg::OFF_CONF: begin
					conf_q <= (conf_q & wmask[asc_pkg::CONF_W-1:0])
					        ^ conf_q ^ (wdata_q[asc_pkg::CONF_W-1:0] & wmask[asc_pkg::CONF_W-1:0]);
				end
				asc_pkg::OFF_ENA:     ena_q <= (ena_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
				asc_pkg::OFF_TIMEOUT: tmo_q <= (tmo_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
				default: ;
			endcase
		end
	end

	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_q <= asc_pkg::RAW_RST;
			irq   <= 1'b0;
		end else begin
			raw_q <= (raw_q & ~clr_bits) | ev_set;
			irq   <= |(((raw_q & ~clr_bits) | ev_set) & ena_q);
		end
	end

	// ----------------------------------------------------------------
	// FIFOs
	// ----------------------------------------------------------------
	logic [31:0] tx_rdata;
	logic        tx_full;
	logic        tx_empty;
	logic [3:0]  tx_level;
	logic        tx_pop;
	logic        rx_push;
	logic [31:0] rx_word;
	logic        rx_full;
	logic [3:0]  rx_level;

	asc_fifo u_tx_fifo (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.clr   (conf_q[asc_pkg::CF_TX_FIFO_RESET]),
		.push  (tx_push),
		.wdata (wdata_q),
		.pop   (tx_pop),
		.rdata (tx_rdata),
		.full  (tx_full),
		.empty (tx_empty),
		.level (tx_level)
	);

	asc_fifo u_rx_fifo (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.clr   (conf_q[asc_pkg::CF_RX_FIFO_RESET]),
		.push  (rx_push),
		.wdata (rx_word),
		.pop   (rx_pop),
		.rdata (rx_rdata),
		.full  (rx_full),
		.empty (rx_empty),
		.level (rx_level)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers and bit clock generator
	// ----------------------------------------------------------------
	logic [2:0] bck_s_q;
	logic [1:0] ws_s_q;
	logic [1:0] sd_s_q;
	logic [7:0] div_q;
	logic       e_fall;
	logic       e_rise;
	logic       m_fall;
	logic       m_rise;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bck_s_q <= 3'h0;
			ws_s_q  <= 2'h0;
			sd_s_q  <= 2'h0;
			div_q   <= 8'h00;
			bck_out <= 1'b0;
		end else begin
			bck_s_q <= {bck_s_q[1:0], bck_in};
			ws_s_q  <= {ws_s_q[0], ws_in};
			sd_s_q  <= {sd_s_q[0], sd_in};
			div_q   <= (m_fall | m_rise) ? 8'h00 : div_q + 8'h01;
			if (m_fall | m_rise) begin
				bck_out <= ~bck_out;
			end
		end
	end

	assign m_rise = (div_q == 8'(asc_pkg::BCK_HALF - 1)) & ~bck_out;
	assign m_fall = (div_q == 8'(asc_pkg::BCK_HALF - 1)) & bck_out;
	assign e_fall = bck_s_q[2] & ~bck_s_q[1];
	assign e_rise = ~bck_s_q[2] & bck_s_q[1];

	// ----------------------------------------------------------------
	// Frame position to word bit index
	// ----------------------------------------------------------------
	function automatic logic [4:0] bit_index(input logic [4:0] pos, input logic rfirst,
	                                         input logic rtop, input logic mono);
		logic half;
		logic right;
		half  = mono ? 1'b0 : pos[4];
		right = half ^ rfirst;
		return {right == rtop, ~pos[3:0]};
	endfunction

	// ----------------------------------------------------------------
	// Transmit engine
	// ----------------------------------------------------------------
	logic        tx_ext;
	logic        tx_fall;
	logic        tx_ws;
	logic        tx_ws_last_q;
	logic [4:0]  tx_cnt_q;
	logic [4:0]  tx_cnt_d;
	logic [4:0]  tx_pos;
	logic [31:0] tx_word_q;
	logic        tx_short;
	logic        tx_first_lvl;
	logic        tx_fstart;
	logic        tx_run;

	assign tx_ext       = conf_q[asc_pkg::CF_TX_EXT_CLK];
	assign tx_short     = conf_q[asc_pkg::CF_TX_SHORT_SYNC];
	assign tx_first_lvl = conf_q[asc_pkg::CF_TX_RIGHT_FIRST];
	assign tx_run       = conf_q[asc_pkg::CF_TX_START] & ~conf_q[asc_pkg::CF_TX_RESET];
	assign tx_fall      = tx_ext ? e_fall : m_fall;
	assign tx_ws        = tx_ext ? ws_s_q[1] : ws_out;
	assign tx_fstart    = tx_short ? (tx_ws & ~tx_ws_last_q)
	                               : (tx_ws == tx_first_lvl && tx_ws_last_q != tx_first_lvl);
	assign tx_cnt_d     = (tx_ext && tx_fstart) ? 5'h00 : tx_cnt_q + 5'h01;
	assign tx_pos       = tx_cnt_d - 5'(conf_q[asc_pkg::CF_TX_ONE_DELAY]);
	assign tx_pop       = tx_fall & tx_run & (tx_pos == 5'h1F);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_q     <= 5'h1F;
			tx_ws_last_q <= 1'b0;
			tx_word_q    <= 32'h0000_0000;
			ws_out       <= 1'b0;
			sd_out       <= 1'b0;
		end else if (conf_q[asc_pkg::CF_TX_RESET]) begin
			tx_cnt_q     <= 5'h1F;
			tx_ws_last_q <= 1'b0;
			tx_word_q    <= 32'h0000_0000;
			sd_out       <= 1'b0;
		end else if (tx_fall) begin
			tx_cnt_q     <= tx_cnt_d;
			tx_ws_last_q <= tx_ws;
			ws_out       <= tx_short ? (tx_cnt_d == 5'h1F) : (tx_cnt_d[4] ^ tx_first_lvl);
			sd_out       <= tx_word_q[bit_index(tx_pos, conf_q[asc_pkg::CF_TX_RIGHT_FIRST],
			                conf_q[asc_pkg::CF_TX_RIGHT_TOP],
			                conf_q[asc_pkg::CF_TX_MONO] & tx_short)];
			if (tx_pos == 5'h1F) begin
				tx_word_q <= (tx_run && !tx_empty) ? tx_rdata : 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive engine
	// ----------------------------------------------------------------
	logic        rx_ext;
	logic        rx_lb;
	logic        rx_fall;
	logic        rx_rise;
	logic        rx_ws;
	logic        rx_ws_last_q;
	logic [4:0]  rx_cnt_q;
	logic [4:0]  rx_pos;
	logic [31:0] rx_acc_q;
	logic        rx_short;
	logic        rx_first_lvl;
	logic        rx_fstart;
	logic        rx_run;
	logic        rx_sync_ext;

	assign rx_lb        = conf_q[asc_pkg::CF_LOOPBACK];
	assign rx_ext       = conf_q[asc_pkg::CF_RX_EXT_CLK];
	assign rx_sync_ext  = rx_lb ? tx_ext : rx_ext;
	assign rx_fall      = rx_sync_ext ? e_fall : m_fall;
	assign rx_rise      = rx_sync_ext ? e_rise : m_rise;
	assign rx_ws        = rx_sync_ext ? ws_s_q[1] : ws_out;
	assign rx_short     = conf_q[asc_pkg::CF_RX_SHORT_SYNC];
	assign rx_first_lvl = conf_q[asc_pkg::CF_RX_RIGHT_FIRST];
	assign rx_run       = conf_q[asc_pkg::CF_RX_START] & ~conf_q[asc_pkg::CF_RX_RESET];
	assign rx_fstart    = rx_short ? (rx_ws & ~rx_ws_last_q)
	                               : (rx_ws == rx_first_lvl && rx_ws_last_q != rx_first_lvl);
	assign rx_pos       = rx_cnt_q - 5'(conf_q[asc_pkg::CF_RX_ONE_DELAY]);

	always_comb begin
		rx_word = rx_acc_q;
		rx_word[bit_index(rx_pos, conf_q[asc_pkg::CF_RX_RIGHT_FIRST],
		                  conf_q[asc_pkg::CF_RX_RIGHT_TOP],
		                  conf_q[asc_pkg::CF_RX_MONO] & rx_short)] = sd_s_q[1];
	end

	assign rx_push = rx_rise & rx_run & (rx_pos == 5'h1F);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_q     <= 5'h1F;
			rx_ws_last_q <= 1'b0;
			rx_acc_q     <= 32'h0000_0000;
		end else if (conf_q[asc_pkg::CF_RX_RESET]) begin
			rx_cnt_q     <= 5'h1F;
			rx_ws_last_q <= 1'b0;
			rx_acc_q     <= 32'h0000_0000;
		end else begin
			if (rx_fall) begin
				rx_cnt_q     <= (rx_sync_ext && rx_fstart) ? 5'h00 : rx_cnt_q + 5'h01;
				rx_ws_last_q <= rx_ws;
			end
			if (rx_rise) begin
				rx_acc_q <= rx_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// Events
	// ----------------------------------------------------------------
	logic [5:0]  lvl_q;
	logic [5:0]  lvl_d;
	logic [15:0] tx_stall_q;
	logic [15:0] rx_stall_q;
	logic        tx_stalled;
	logic        rx_stalled;

	assign tx_stalled = tx_run & tx_empty;
	assign rx_stalled = rx_run & rx_full;
	assign lvl_d = {tx_empty, tx_full, rx_empty, rx_full,
	                tx_level <= asc_pkg::AEMPTY_LVL, rx_level >= asc_pkg::AFULL_LVL};

	always_comb begin
		ev_set = 16'h0000;
		ev_set[asc_pkg::EV_TX_QUEUE_EMPTY] = lvl_d[5] & ~lvl_q[5];
		ev_set[asc_pkg::EV_TX_QUEUE_FULL]  = lvl_d[4] & ~lvl_q[4];
		ev_set[asc_pkg::EV_RX_QUEUE_EMPTY] = lvl_d[3] & ~lvl_q[3];
		ev_set[asc_pkg::EV_RX_QUEUE_FULL]  = lvl_d[2] & ~lvl_q[2];
		ev_set[asc_pkg::EV_TX_LOW_LEVEL]   = lvl_d[1] & ~lvl_q[1];
		ev_set[asc_pkg::EV_RX_HIGH_LEVEL]  = lvl_d[0] & ~lvl_q[0];
		ev_set[asc_pkg::EV_TX_TIMEOUT] = tx_stalled && tx_stall_q == tmo_q;
		ev_set[asc_pkg::EV_RX_TIMEOUT] = rx_stalled && rx_stall_q == tmo_q;
	end

	// Stall counters stop one past the limit so a timeout fires once per stall
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q      <= 6'h2A;
			tx_stall_q <= 16'h0000;
			rx_stall_q <= 16'h0000;
		end else begin
			lvl_q      <= lvl_d;
			tx_stall_q <= !tx_stalled ? 16'h0000 : tx_stall_q + 16'(tx_stall_q <= tmo_q);
			rx_stall_q <= !rx_stalled ? 16'h0000 : rx_stall_q + 16'(rx_stall_q <= tmo_q);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence wr_to_txwin_s;
		do_wr && awaddr_q == asc_pkg::OFF_TXWIN && wstrb_q != 4'h0 && !tx_full
		&& !conf_q[asc_pkg::CF_TX_FIFO_RESET] && !tx_pop;
	endsequence

	tx_push_a: assert property (wr_to_txwin_s |=> tx_level == $past(tx_level) + 4'h1)
		else $error("transmit window write did not fill the FIFO");
	rx_pop_a: assert property (ar_take && s_axi_araddr == asc_pkg::OFF_RXWIN && !rx_empty
		&& !rx_push && !conf_q[asc_pkg::CF_RX_FIFO_RESET] |=> rx_level == $past(rx_level) - 4'h1
		&& s_axi_rdata == $past(rx_rdata))
		else $error("receive window read did not pop the FIFO");
	fifo_clear_a: assert property (conf_q[asc_pkg::CF_TX_FIFO_RESET] |=> tx_empty)
		else $error("transmit FIFO not emptied by its reset bit");
	eng_reset_a: assert property (conf_q[asc_pkg::CF_TX_RESET] |=> tx_cnt_q == 5'h1F
		&& !sd_out)
		else $error("transmit engine not held in reset");
	rx_idle_a: assert property (!conf_q[asc_pkg::CF_RX_START] |-> !rx_push)
		else $error("receiver stored a word while stopped");
	raw_sticky_a: assert property (raw_q[0] && !clr_bits[0] |=> raw_q[0])
		else $error("raw event bit dropped without a clear");
	irq_gate_a: assert property (##1 irq == |(raw_q & $past(ena_q)))
		else $error("interrupt output disagrees with masked status");
	low_level_a: assert property ($rose(tx_level <= asc_pkg::AEMPTY_LVL)
		|=> raw_q[asc_pkg::EV_TX_LOW_LEVEL])
		else $error("almost empty event missing");
	timeout_a: assert property (tx_stalled [*2] ##0 tx_stall_q == tmo_q
		|=> raw_q[asc_pkg::EV_TX_TIMEOUT])
		else $error("transmit timeout event missing");
	loop_clk_a: assert property (rx_lb |-> rx_fall == tx_fall)
		else $error("loopback receiver not on transmit clock");
endmodule // asc_regs
`default_nettype wire

/* tb/asc_codec_model.sv */
// Behavioural codec on the far side of the serial pins
`timescale 1ns/10ps
`default_nettype none
module asc_codec_model (
	input  wire logic run,
	input  wire logic sd_out,
	output logic      bck_in,
	output logic      ws_in,
	output logic      sd_in
);
	int n_bit = 0;
	initial bck_in = 1'b0;
	initial ws_in = 1'b0;
	initial sd_in = 1'b0;
	// ------------------------------
	// Clock only while run is set
	// ------------------------------
	always #80 begin
		if (run) begin
			bck_in <= ~bck_in;
			if (bck_in) begin
				n_bit <= (n_bit + 1) % 32;
				ws_in <= (n_bit >= 15 && n_bit < 31);
				sd_in <= sd_out;
			end
		end else begin
			// Idle data line toggles every 80 ns while the clock is held low
			bck_in <= 1'b0;
			sd_in <= ~sd_in;
		end
	end
endmodule // asc_codec_model
`default_nettype wire

/* tb/tb.sv */
// Register-level testbench of the audio serial port
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0, rstn = 1'b0, run = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, bck_in, ws_in, sd_in;
	logic bck_out, ws_out, sd_out, irq;
	int checks = 0, n_mismatch = 0;
	asc_regs i_asc_regs (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bck_in(bck_in), .ws_in(ws_in), .sd_in(sd_in),
		.bck_out(bck_out), .ws_out(ws_out), .sd_out(sd_out), .irq(irq));
	asc_codec_model i_asc_codec_model (.run(run), .sd_out(sd_out), .bck_in(bck_in),
		.ws_in(ws_in), .sd_in(sd_in));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// ------------------------------
	// Bus tasks
	// ------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		r = bresp;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		@(posedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Frames before the word is loaded carry zeros, so take the first non-zero one
	task automatic frame;
		d = 32'h0;
		for (int f = 0; f < 3 && d == 32'h0; f++) begin
			@(negedge ws_out);
			for (int b = 0; b < 32; b++) begin
				@(posedge bck_out);
				d = {d[30:0], sd_out};
			end
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		report_and_stop;
	end
	// ------------------------------
	// Scenarios
	// ------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(asc_pkg::OFF_RAW);
		chk("raw", 32'h0, d);
		rd(asc_pkg::OFF_CONF);
		chk("conf", 32'h0, d);
		rd(8'h40);
		chk("unmapped", {30'h0, asc_pkg::RESP_SLVERR}, {30'h0, r});
		wr(asc_pkg::OFF_CONF, 32'h0007FFC0);
		rd(asc_pkg::OFF_CONF);
		chk("conf fields", 32'h0007FFC0, d);
		wr(asc_pkg::OFF_CONF, 32'h0);
		for (int i = 0; i < 8; i++) wr(asc_pkg::OFF_TXWIN, 32'hA5A50000 + i);
		rd(asc_pkg::OFF_RAW);
		chk("tx full", 32'h10, d & 32'h10);
		rd(asc_pkg::OFF_RXWIN);
		chk("rx empty read", 32'h0, d);
		wr(asc_pkg::OFF_ENA, 32'h10);
		repeat (2) @(posedge sys_clk);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(asc_pkg::OFF_CLR, 32'h10);
		rd(asc_pkg::OFF_RAW);
		chk("raw cleared", 32'h0, d & 32'h10);
		chk("irq clear", 32'h0, {31'h0, irq});
		wr(asc_pkg::OFF_CONF, 32'h4);
		wr(asc_pkg::OFF_CONF, 32'h0);
		rd(asc_pkg::OFF_RAW);
		chk("tx emptied", 32'h20, d & 32'h20);
		wr(asc_pkg::OFF_TIMEOUT, 32'h10);
		run <= 1'b1;
		wr(asc_pkg::OFF_CONF, 32'h10);
		repeat (40) @(posedge sys_clk);
		rd(asc_pkg::OFF_RAW);
		chk("tx stall", 32'h80, d & 32'h80);
		wr(asc_pkg::OFF_CONF, 32'h11);
		wr(asc_pkg::OFF_CONF, 32'h10);
		wr(asc_pkg::OFF_TXWIN, 32'h9C3A5E71);
		frame;
		chk("serial frame", 32'h9C3A5E71, d);
		wr(asc_pkg::OFF_CONF, 32'h10030);
		wr(asc_pkg::OFF_TXWIN, 32'h9C3A5E71);
		frame;
		chk("right at top", 32'h5E719C3A, d);
		rd(asc_pkg::OFF_RXWIN);
		chk("rx window resp", {30'h0, asc_pkg::RESP_OKAY}, {30'h0, r});
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
